// file: ifeb_bank.sv
// ifeb_bank: pending flags for groups 0,1,3,4 and source enables for groups 0,1.
// assumes a wishbone master on clk_i and source pulses synchronous to clk_i.
//
// Chosen here: the register addresses and register access over Wishbone.
module ifeb_bank (
    input wire logic clk_i, // system clock, 50 MHz
    input wire logic rst_i, // synchronous reset, high
    input wire logic ce_i, // clock enable, freezes all state when low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data, registered
    output logic wb_ack_o, // wishbone acknowledge
    input wire ifeb_pkg::ifeb_src_t src_i, // source request pulses
    output logic [15:0] fwd0_o, // group 0 requests to arbitration
    output logic [15:0] fwd1_o, // group 1 requests to arbitration
    output logic [15:0] pend3_o, // group 3 pending, enables live elsewhere
    output logic [15:0] pend4_o, // group 4 pending, enables live elsewhere
    output logic irq_o // level interrupt, any unmasked group forwarding (groups 0,1) or pending (groups 3,4)
);
    ifeb_pkg::ifeb_wb_req_t req;
    logic take;
    logic wr;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [15:0] flags0, flags1, flags3, flags4;
    logic [15:0] clr0, clr1, clr3, clr4;
    logic [15:0] en0_reg, en0_next, en1_reg, en1_next;
    logic [3:0] mask_reg, mask_next;
    logic [3:0] grp_stat;
    logic [31:0] rdat_reg, rdat_next;

    // bundle the bus request
    always_comb begin
        req.cyc = wb_cyc_i;
        req.stb = wb_stb_i;
        req.we = wb_we_i;
        req.sel = wb_sel_i;
        req.adr = wb_adr_i;
        req.dat = wb_dat_i;
    end

    ifeb_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .req_i(req.cyc && req.stb),
        .ack_o(wb_ack_o),
        .take_o(take)
    );

    // only the two low byte lanes carry register bits
    assign wr = take && req.we;
    assign wmask = {{8{req.sel[1]}}, {8{req.sel[0]}}};
    assign wdata = req.dat[15:0] & wmask;

    // software clears a flag by writing one to it
    always_comb begin
        clr0 = (wr && req.adr == ifeb_pkg::ADDR_FLAGS0) ? wdata : 16'h0000;
        clr1 = (wr && req.adr == ifeb_pkg::ADDR_FLAGS1) ? wdata : 16'h0000;
        clr3 = (wr && req.adr == ifeb_pkg::ADDR_FLAGS3) ? wdata : 16'h0000;
        clr4 = (wr && req.adr == ifeb_pkg::ADDR_FLAGS4) ? wdata : 16'h0000;
    end

    // flag banks; the IMPL masks fix the source positions
    ifeb_flag_reg #(.IMPL(ifeb_pkg::IMPL_FLAGS0)) u_flags0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(src_i.grp0),
        .clr_i(clr0),
        .flags_o(flags0)
    );
    ifeb_flag_reg #(.IMPL(ifeb_pkg::IMPL_FLAGS1)) u_flags1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(src_i.grp1),
        .clr_i(clr1),
        .flags_o(flags1)
    );
    ifeb_flag_reg #(.IMPL(ifeb_pkg::IMPL_FLAGS3)) u_flags3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(src_i.grp3),
        .clr_i(clr3),
        .flags_o(flags3)
    );
    ifeb_flag_reg #(.IMPL(ifeb_pkg::IMPL_FLAGS4)) u_flags4 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(src_i.grp4),
        .clr_i(clr4),
        .flags_o(flags4)
    );

    // enables share the flag layout; unselected lanes keep their value
    always_comb begin
        en0_next = en0_reg;
        en1_next = en1_reg;
        mask_next = mask_reg;
        if (wr && req.adr == ifeb_pkg::ADDR_ENABLES0) begin
            en0_next = ((en0_reg & ~wmask) | wdata) & ifeb_pkg::IMPL_FLAGS0;
        end
        if (wr && req.adr == ifeb_pkg::ADDR_ENABLES1) begin
            en1_next = ((en1_reg & ~wmask) | wdata) & ifeb_pkg::IMPL_FLAGS1;
        end
        if (wr && req.adr == ifeb_pkg::ADDR_IRQ_MASK && req.sel[0]) begin
            mask_next = req.dat[3:0] & ifeb_pkg::IMPL_IRQ_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en0_reg <= ifeb_pkg::RESET_BANK;
            en1_reg <= ifeb_pkg::RESET_BANK;
            mask_reg <= ifeb_pkg::RESET_MASK;
        end else if (ce_i) begin
            en0_reg <= en0_next;
            en1_reg <= en1_next;
            mask_reg <= mask_next;
        end
    end

    // a source reaches arbitration only with flag and enable both set
    assign fwd0_o = flags0 & en0_reg;
    assign fwd1_o = flags1 & en1_reg;
    assign pend3_o = flags3;
    assign pend4_o = flags4;

    // group summary; groups 3 and 4 count unconditionally, their enables sit elsewhere
    assign grp_stat = {|flags4, |flags3, |fwd1_o, |fwd0_o};
    assign irq_o = |(grp_stat & mask_reg);

    // read mux; unmapped offsets answer zero
    always_comb begin
        rdat_next = rdat_reg;
        if (take && !req.we) begin
            case (req.adr)
                ifeb_pkg::ADDR_FLAGS0: rdat_next = {16'h0000, flags0};
                ifeb_pkg::ADDR_FLAGS1: rdat_next = {16'h0000, flags1};
                ifeb_pkg::ADDR_FLAGS3: rdat_next = {16'h0000, flags3};
                ifeb_pkg::ADDR_FLAGS4: rdat_next = {16'h0000, flags4};
                ifeb_pkg::ADDR_ENABLES0: rdat_next = {16'h0000, en0_reg};
                ifeb_pkg::ADDR_ENABLES1: rdat_next = {16'h0000, en1_reg};
                ifeb_pkg::ADDR_IRQ_MASK: rdat_next = {28'h0000000, mask_reg};
                default: rdat_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= 32'h00000000;
        end else if (ce_i) begin
            rdat_reg <= rdat_next;
        end
    end

    assign wb_dat_o = rdat_reg;

    // checks; the |=> ones look at registered state one edge after the cause
    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ((flags0 & ~ifeb_pkg::IMPL_FLAGS0) == 16'h0000)
        && ((flags1 & ~ifeb_pkg::IMPL_FLAGS1) == 16'h0000)
        && ((flags3 & ~ifeb_pkg::IMPL_FLAGS3) == 16'h0000)
        && ((flags4 & ~ifeb_pkg::IMPL_FLAGS4) == 16'h0000))
        else $error("unimplemented flag bit set");
    a_unimpl_enables: assert property (@(posedge clk_i) disable iff (rst_i)
        ((en0_reg & ~ifeb_pkg::IMPL_FLAGS0) == 16'h0000)
        && ((en1_reg & ~ifeb_pkg::IMPL_FLAGS1) == 16'h0000))
        else $error("unimplemented enable bit set");
    a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !req.we && req.adr > ifeb_pkg::ADDR_IRQ_MASK
        |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_set_records: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && src_i.grp0[ifeb_pkg::POS_SERIAL_RX] |=> flags0[ifeb_pkg::POS_SERIAL_RX])
        else $error("receiver request not recorded");
    // every implemented position must keep a request seen on the edge before
    a_set_group0: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (flags0 & $past(src_i.grp0)) == ($past(src_i.grp0) & ifeb_pkg::IMPL_FLAGS0))
        else $error("group 0 request not recorded");
    a_set_group1: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (flags1 & $past(src_i.grp1)) == ($past(src_i.grp1) & ifeb_pkg::IMPL_FLAGS1))
        else $error("group 1 request not recorded");
    a_set_group3: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (flags3 & $past(src_i.grp3)) == ($past(src_i.grp3) & ifeb_pkg::IMPL_FLAGS3))
        else $error("group 3 request not recorded");
    a_set_group4: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (flags4 & $past(src_i.grp4)) == ($past(src_i.grp4) & ifeb_pkg::IMPL_FLAGS4))
        else $error("group 4 request not recorded");
    // only a source may raise a flag, only a written one may drop it
    a_no_stray_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (flags0 & ~$past(flags0) & ~$past(src_i.grp0)) == 16'h0000
        && (flags1 & ~$past(flags1) & ~$past(src_i.grp1)) == 16'h0000)
        else $error("flag set with no request");
    a_stray_set_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (flags3 & ~$past(flags3) & ~$past(src_i.grp3)) == 16'h0000
        && (flags4 & ~$past(flags4) & ~$past(src_i.grp4)) == 16'h0000)
        else $error("flag set with no request");
    a_clear_needs_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (~flags0 & $past(flags0) & ~$past(clr0)) == 16'h0000
        && (~flags1 & $past(flags1) & ~$past(clr1)) == 16'h0000)
        else $error("flag cleared with no write");
    a_clear_write_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (~flags3 & $past(flags3) & ~$past(clr3)) == 16'h0000
        && (~flags4 & $past(flags4) & ~$past(clr4)) == 16'h0000)
        else $error("flag cleared with no write");
    a_clear_takes: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (flags0 & $past(clr0) & ~$past(src_i.grp0)) == 16'h0000
        && (flags3 & $past(clr3) & ~$past(src_i.grp3)) == 16'h0000)
        else $error("written one left flag set");
    a_set_over_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && src_i.grp1[0] && clr1[0] |=> flags1[0])
        else $error("set lost against clear");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && flags4[1] && !clr4[1] |=> flags4[1])
        else $error("flag dropped without clear");
    a_fwd_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        fwd0_o[ifeb_pkg::POS_SERIAL_RX] == (flags0[ifeb_pkg::POS_SERIAL_RX]
        && en0_reg[ifeb_pkg::POS_SERIAL_RX]))
        else $error("receiver forward mismatch");
    // the enable may be written in the same cycle, so compare against its new value
    a_disabled_records: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !en1_reg[4] && src_i.grp1[4] |=> flags1[4] && (fwd1_o[4] == en1_reg[4]))
        else $error("disabled source misbehaves");
    a_enable_hold0: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && req.adr == ifeb_pkg::ADDR_ENABLES0) |=> $stable(en0_reg))
        else $error("enable 0 changed without a write");
    a_enable_hold1: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && req.adr == ifeb_pkg::ADDR_ENABLES1) |=> $stable(en1_reg))
        else $error("enable 1 changed without a write");
    a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && req.adr == ifeb_pkg::ADDR_ENABLES0 && req.sel[0] && req.dat[0]
        |=> en0_reg[ifeb_pkg::POS_EXT_IRQ0])
        else $error("enable write lost");
    a_enable_lane0: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && req.adr == ifeb_pkg::ADDR_ENABLES0 && req.sel[1]
        |=> en0_reg[15:8] == ($past(wb_dat_i[15:8]) & ifeb_pkg::IMPL_FLAGS0[15:8]))
        else $error("enable 0 high lane lost");
    a_enable_lane1: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && req.adr == ifeb_pkg::ADDR_ENABLES1 && req.sel[0]
        |=> en1_reg[7:0] == ($past(wb_dat_i[7:0]) & ifeb_pkg::IMPL_FLAGS1[7:0]))
        else $error("enable 1 low lane lost");
    a_enable_bit13: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && req.adr == ifeb_pkg::ADDR_ENABLES1 && req.sel[1]
        |=> en1_reg[13] == $past(wb_dat_i[13]))
        else $error("enable 1 bit 13 lost");
    a_read_flags0: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !req.we && req.adr == ifeb_pkg::ADDR_FLAGS0
        |=> wb_dat_o == {16'h0000, $past(flags0)})
        else $error("flag read mismatch");
    a_read_enables1: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !req.we && req.adr == ifeb_pkg::ADDR_ENABLES1
        |=> wb_dat_o == {16'h0000, $past(en1_reg)})
        else $error("enable read mismatch");
    a_irq_forwarded: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask_reg[0] && fwd0_o != 16'h0000) || (mask_reg[1] && fwd1_o != 16'h0000)
        |-> irq_o)
        else $error("unmasked forwarded source gives no interrupt");
    a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        mask_reg == 4'h0 |-> !irq_o)
        else $error("interrupt while all groups masked");
    a_reset_clear: assert property (@(posedge clk_i)
        rst_i |=> (en0_reg == ifeb_pkg::RESET_BANK) && (en1_reg == ifeb_pkg::RESET_BANK)
        && (flags0 == ifeb_pkg::RESET_BANK) && (flags1 == ifeb_pkg::RESET_BANK)
        && (flags3 == ifeb_pkg::RESET_BANK) && (flags4 == ifeb_pkg::RESET_BANK)
        && (mask_reg == ifeb_pkg::RESET_MASK) && !wb_ack_o)
        else $error("state not cleared by reset");
    // a frozen clock enable may hold ack, so only a live cycle must drop it
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without a request");
    a_take_once: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> !take)
        else $error("request committed twice");
    a_frozen_state: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(flags0) && $stable(en0_reg) && $stable(wb_ack_o))
        else $error("state moved while clock enable low");
    c_read_flags: cover property (@(posedge clk_i) take && !req.we
        && req.adr == ifeb_pkg::ADDR_FLAGS0);
    c_irq_rise: cover property (@(posedge clk_i) !irq_o ##1 irq_o);
    c_clear_hit: cover property (@(posedge clk_i) |clr3);
    c_set_meets_clear: cover property (@(posedge clk_i) ce_i && |(src_i.grp0 & clr0));
    c_enable_write: cover property (@(posedge clk_i) wr && req.adr == ifeb_pkg::ADDR_ENABLES1);
endmodule : ifeb_bank

// file: ifeb_pkg.sv
// ifeb_pkg: shared constants and types for the interrupt flag and enable bank.
// assumes a 16-bit register file reached over a 32-bit classic wishbone slave.
package ifeb_pkg;
    // word byte addresses of the bank's registers
    localparam logic [7:0] ADDR_FLAGS0 = 8'h00;
    localparam logic [7:0] ADDR_FLAGS1 = 8'h04;
    localparam logic [7:0] ADDR_FLAGS3 = 8'h08;
    localparam logic [7:0] ADDR_FLAGS4 = 8'h0C;
    localparam logic [7:0] ADDR_ENABLES0 = 8'h10;
    localparam logic [7:0] ADDR_ENABLES1 = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    // implemented bit masks; every other bit reads zero and ignores writes
    localparam logic [15:0] IMPL_FLAGS0 = 16'h3FEF;
    localparam logic [15:0] IMPL_FLAGS1 = 16'h20DB;
    localparam logic [15:0] IMPL_FLAGS3 = 16'h8600;
    localparam logic [15:0] IMPL_FLAGS4 = 16'h0602;
    // mask register bit for each flag group (0,1,3,4)
    localparam logic [3:0] IMPL_IRQ_MASK = 4'hF;
    localparam logic [15:0] RESET_BANK = 16'h0000;
    localparam logic [3:0] RESET_MASK = 4'h0;
    // positions of the group 0 sources
    localparam int POS_EXT_IRQ0 = 0;
    localparam int POS_CAPTURE1 = 1;
    localparam int POS_COMPARE1 = 2;
    localparam int POS_TIMER1 = 3;
    localparam int POS_CAPTURE2 = 5;
    localparam int POS_COMPARE2 = 6;
    localparam int POS_TIMER2 = 7;
    localparam int POS_TIMER3 = 8;
    localparam int POS_SYNC_SERIAL_ERROR = 9;
    localparam int POS_SYNC_SERIAL_EVENT = 10;
    localparam int POS_SERIAL_RX = 11;
    localparam int POS_SERIAL_TX = 12;
    localparam int POS_CONVERSION_DONE = 13;

    // one bus request as the slave sees it
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } ifeb_wb_req_t;

    // raw source pulses per group, aligned with the flag positions
    typedef struct packed {
        logic [15:0] grp0;
        logic [15:0] grp1;
        logic [15:0] grp3;
        logic [15:0] grp4;
    } ifeb_src_t;
endpackage : ifeb_pkg

// file: ifeb_flag_reg.sv
// ifeb_flag_reg: one 16-bit pending flag register, hardware set, write-one clear.
// assumes set pulses synchronous to clk_i; IMPL marks the bits that exist.
module ifeb_flag_reg #(
    parameter logic [15:0] IMPL = 16'hFFFF
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic ce_i, // clock enable
    input wire logic [15:0] set_i, // request pulses from sources
    input wire logic [15:0] clr_i, // write-one-to-clear bits
    output logic [15:0] flags_o // current flags
);
    logic [15:0] flags_reg;
    logic [15:0] flags_next;

    // set beats clear, so a request landing with a clear is kept
    always_comb begin
        flags_next = ((flags_reg & ~clr_i) | set_i) & IMPL;
    end

    // zero after reset so nothing is pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= ifeb_pkg::RESET_BANK;
        end else if (ce_i) begin
            flags_reg <= flags_next;
        end
    end

    assign flags_o = flags_reg;
endmodule : ifeb_flag_reg

// file: ifeb_wb_slave.sv
// ifeb_wb_slave: classic wishbone handshake, one ack per request.
// assumes cyc/stb held until ack; ack rises one cycle after the request.
module ifeb_wb_slave (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic ce_i, // clock enable
    input wire logic req_i, // cyc and stb both high
    output logic ack_o, // one-cycle acknowledge
    output logic take_o // access is committed this cycle
);
    logic ack_reg;
    logic ack_next;

    // ack drops the cycle after it is given, leaving a gap between requests
    always_comb begin
        ack_next = req_i && !ack_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= ack_next;
        end
    end

    assign ack_o = ack_reg;
    assign take_o = ce_i && ack_next;
endmodule : ifeb_wb_slave

// file: ifeb_src_model.sv
// ifeb_src_model: stands in for the peripherals that raise requests.
// assumes the bench hands it a pattern and a strobe on the rising edge of clk_i.
module ifeb_src_model (
    input wire logic clk_i, // system clock
    input wire logic fire_i, // emit the pattern for one cycle
    input wire ifeb_pkg::ifeb_src_t pat_i, // requests to raise
    output ifeb_pkg::ifeb_src_t src_o // pulses into the bank
);
    timeunit 1ns;
    timeprecision 1ps;
    // a peripheral raises its request for one cycle, then lets it fall
    // one driver only; the lines are unknown until the first edge, which reset covers
    always @(posedge clk_i) begin
        src_o <= fire_i ? pat_i : '0;
    end
endmodule : ifeb_src_model

// file: ifeb_bank_bench.sv
// ifeb_bank_bench: drives the bank over wishbone and from the source model.
// assumes the offsets and bit masks of ifeb_pkg; an integer model predicts every result.
module ifeb_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i;
    logic rst_i;
    logic ce_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [3:0] wb_sel_i;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic fire;
    ifeb_pkg::ifeb_src_t pat;
    ifeb_pkg::ifeb_src_t src;
    logic [15:0] fwd0_o;
    logic [15:0] fwd1_o;
    logic [15:0] pend3_o;
    logic [15:0] pend4_o;
    logic irq_o;
    logic [15:0] wd;
    logic [3:0] sel;
    logic [31:0] rd;
    logic [15:0] impl [4];
    int mismatches;
    int checks_done;
    int cycles;
    int seed;
    int g;
    int bm;
    int msk;
    int flg [4];
    int en [2];

    ifeb_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src),
        .fwd0_o(fwd0_o), .fwd1_o(fwd1_o), .pend3_o(pend3_o), .pend4_o(pend4_o), .irq_o(irq_o));
    ifeb_src_model u_src (.clk_i(clk_i), .fire_i(fire), .pat_i(pat), .src_o(src));

    // 50 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // a hung handshake would otherwise stall the run forever
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // classic single cycle; held until ack, then one idle cycle before the next
    task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] d,
                       input logic [3:0] s, output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {16'h0000, d};
        wb_sel_i <= s;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, adr, 16'h0000, 4'hF, r);
        check(r, exp);
    endtask : rd_chk

    function automatic int lanes(input logic [3:0] s);
        return {s[1] ? 8'hFF : 8'h00, s[0] ? 8'hFF : 8'h00};
    endfunction : lanes

    // groups 3 and 4 have no enables here, so any flag counts
    function automatic logic exp_irq();
        return (msk[0] && (flg[0] & en[0]) != 0) || (msk[1] && (flg[1] & en[1]) != 0)
            || (msk[2] && flg[2] != 0) || (msk[3] && flg[3] != 0);
    endfunction : exp_irq

    // main sequence: reset values, then rounds of set, enable, mask and clear
    initial begin
        seed = 85;
        impl = '{ifeb_pkg::IMPL_FLAGS0, ifeb_pkg::IMPL_FLAGS1, ifeb_pkg::IMPL_FLAGS3,
                 ifeb_pkg::IMPL_FLAGS4};
        flg = '{0, 0, 0, 0};
        en = '{0, 0};
        msk = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h00000000;
        fire = 1'b0;
        pat = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (g = 0; g < 8; g++) rd_chk(8'(4 * g), 32'h0);
        bus(1'b1, 8'h1C, 16'hFFFF, 4'hF, rd);
        rd_chk(8'h1C, 32'h0);
        repeat (12) begin
            pat = {$random(seed), $random(seed)};
            @(posedge clk_i);
            fire <= 1'b1;
            @(posedge clk_i);
            fire <= 1'b0;
            repeat (2) @(posedge clk_i);
            // a few frozen cycles; the reads below show that nothing moved
            ce_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            ce_i <= 1'b1;
            for (g = 0; g < 4; g++) begin
                flg[g] = flg[g] | (pat[63 - 16 * g -: 16] & impl[g]);
                rd_chk(8'(4 * g), flg[g]);
            end
            for (g = 0; g < 2; g++) begin
                wd = $random(seed);
                sel = $random(seed);
                bm = lanes(sel);
                en[g] = (en[g] & ~bm) | (wd & bm & impl[g]);
                bus(1'b1, 8'(16 + 4 * g), wd, sel, rd);
                rd_chk(8'(16 + 4 * g), en[g]);
            end
            check(fwd0_o, flg[0] & en[0]);
            check(fwd1_o, flg[1] & en[1]);
            check(pend3_o, flg[2]);
            check(pend4_o, flg[3]);
            msk = $random(seed) & 15;
            bus(1'b1, ifeb_pkg::ADDR_IRQ_MASK, 16'(msk), 4'hF, rd);
            rd_chk(ifeb_pkg::ADDR_IRQ_MASK, msk);
            check(irq_o, exp_irq());
            g = $unsigned($random(seed)) % 4;
            wd = $random(seed);
            sel = $random(seed);
            flg[g] = flg[g] & ~(wd & lanes(sel));
            bus(1'b1, 8'(4 * g), wd, sel, rd);
            rd_chk(8'(4 * g), flg[g]);
            check(irq_o, exp_irq());
        end
        print_verdict();
    end
endmodule : ifeb_bank_bench
